// file: verilog/sfx_exc_unit.sv
// Underflow, overflow and inexact response logic for SIMD floating-point results.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// What this block does
// - Single results rounded with unbounded exponent below min normal flag underflow.
// - Double results rounded with unbounded exponent below min normal flag underflow.
// - Masked underflow delivers the bounded result: zero, denormal or normal.
// - Masked underflow sets underflow and precision together, only if inexact.
// - Unmasked underflow hands over result times 2^192 single, 2^1536 double.
// - Unmasked underflow always sets underflow; precision only when inexact.
// - Inexact is detected when the result is not exactly representable.
// - Masked inexact delivers bounded rounded result and sets precision flag.
// - Inexact may be signalled together with masked underflow or overflow.
// - Unmasked inexact traps only without unmasked underflow or overflow.
// - Unmasked inexact with masked overflow sets overflow, gives overflow result.
// - Unmasked inexact with masked underflow sets underflow, gives denormal result.
// - Unmasked inexact alone gives bounded rounded result, sets precision flag.
// - Unmasked overflow hands over result over 2^192 single, 2^1536 double.
// - Every unmasked exception traps through vector 19.

module sfx_exc_unit
    import sfx_pkg::*;
#(
    parameter int EXP_W = 16
)
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        req_valid,
    input  wire sfx_req_t    req,
    output logic             res_valid,
    output logic [63:0]      res_result,
    output sfx_flags_t       res_flags,
    output logic             trap,
    output logic [7:0]       exc_vector,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq
);
    // The exponent datapath is fixed at 16 bits; other widths are refused.
    if (EXP_W != 16) begin : g_exp_w_check
        $error("sfx_exc_unit: EXP_W must be 16");
    end

    // ====================================================================
    // Helpers
    function automatic logic [63:0] fp_pack(input logic dbl, input logic sign,
                                            input logic [12:0] bexp,
                                            input logic [51:0] frac);
        if (dbl) begin
            fp_pack = {sign, bexp[10:0], frac};
        end else begin
            fp_pack = {32'h0, sign, bexp[7:0], frac[22:0]};
        end
    endfunction

    function automatic logic [12:0] bexp_of(input logic signed [15:0] e, input int bias);
        bexp_of = 13'(int'(e) + bias);
    endfunction

    // ====================================================================
    // Control and status registers
    logic [4:0]  ctrl;
    sfx_flags_t  flags;
    logic [2:0]  irq_mask;
    sfx_rmode_t  rmode;
    logic        om;
    logic        um;
    logic        pm;

    assign rmode = sfx_rmode_t'(ctrl[SFX_CTRL_RM_LSB +: 2]);
    assign om    = ctrl[SFX_CTRL_OM_BIT];
    assign um    = ctrl[SFX_CTRL_UM_BIT];
    assign pm    = ctrl[SFX_CTRL_PM_BIT];

    // ====================================================================
    // Rounding with unbounded exponent and denormalisation
    logic        [6:0]  prec;
    logic signed [15:0] emin;
    logic signed [15:0] emax;
    int                 bias;
    int                 scale;
    logic        [64:0] u_q;
    logic               u_inx;
    logic        [64:0] d_q;
    logic               d_inx;
    logic signed [15:0] exp_r;
    logic signed [15:0] shift_d;
    logic        [63:0] d_sig;
    logic        [6:0]  d_keep;
    logic               nz;
    logic               tiny;
    logic               huge;

    always_comb begin
        prec    = req.dbl ? 7'(SFX_DP_PREC) : 7'(SFX_SP_PREC);
        emin    = req.dbl ? 16'(SFX_DP_EMIN) : 16'(SFX_SP_EMIN);
        emax    = req.dbl ? 16'(SFX_DP_EMAX) : 16'(SFX_SP_EMAX);
        bias    = req.dbl ? SFX_DP_BIAS : SFX_SP_BIAS;
        scale   = req.dbl ? SFX_DP_SCALE : SFX_SP_SCALE;
        nz      = req.sig != 64'h0;
        exp_r   = $signed(req.exp) + 16'(u_q[prec]);
        tiny    = nz && (exp_r < emin);
        huge    = nz && (exp_r > emax);
        shift_d = emin - $signed(req.exp);
        // Far below the smallest denormal only the sticky bit matters.
        if (shift_d > 16'(prec)) begin
            d_sig  = 64'h1;
            d_keep = 7'd0;
        end else begin
            d_sig  = req.sig;
            d_keep = prec - 7'(shift_d);
        end
    end

    sfx_round u_round_unb (
        .sig     (req.sig),
        .keep    (prec),
        .sign    (req.sign),
        .rmode   (rmode),
        .q       (u_q),
        .inexact (u_inx)
    );

    // Rounding once from the exact value avoids double rounding on denormals.
    sfx_round u_round_den (
        .sig     (d_sig),
        .keep    (d_keep),
        .sign    (req.sign),
        .rmode   (rmode),
        .q       (d_q),
        .inexact (d_inx)
    );

    // ====================================================================
    // Response selection
    logic [63:0] next_result;
    sfx_flags_t  next_flags;
    logic        next_trap;
    logic        to_inf;
    logic [63:0] den_res;

    always_comb begin
        unique case (rmode)
            SFX_RM_NEAREST: to_inf = 1'b1;
            SFX_RM_DOWN:    to_inf = req.sign;
            SFX_RM_UP:      to_inf = ~req.sign;
            SFX_RM_ZERO:    to_inf = 1'b0;
        endcase
        // A denormal's encoding is its rounded integer; reaching 2^(p-1) gives min normal.
        den_res = req.dbl ? {req.sign, d_q[62:0]} : {32'h0, req.sign, d_q[30:0]};
        next_flags  = '0;
        next_trap   = 1'b0;
        next_result = fp_pack(req.dbl, req.sign, bexp_of(exp_r, bias), u_q[51:0]);
        if (!nz) begin
            next_result = fp_pack(req.dbl, req.sign, 13'h0, 52'h0);
        end else if (huge && !om) begin
            next_result = fp_pack(req.dbl, req.sign,
                                  bexp_of(exp_r - 16'(scale), bias), u_q[51:0]);
            next_flags.overflow  = 1'b1;
            next_flags.precision = u_inx;
            next_trap            = 1'b1;
        end else if (huge) begin
            next_result = to_inf
                ? fp_pack(req.dbl, req.sign, bexp_of(emax + 16'h1, bias), 52'h0)
                : fp_pack(req.dbl, req.sign, bexp_of(emax, bias), {52{1'b1}});
            next_flags.overflow  = 1'b1;
            next_flags.precision = 1'b1;
            next_trap            = !pm;
        end else if (tiny && !um) begin
            next_result = fp_pack(req.dbl, req.sign,
                                  bexp_of(exp_r + 16'(scale), bias), u_q[51:0]);
            next_flags.underflow = 1'b1;
            next_flags.precision = u_inx;
            next_trap            = 1'b1;
        end else if (tiny) begin
            next_result          = den_res;
            next_flags.underflow = d_inx;
            next_flags.precision = d_inx;
            next_trap            = d_inx && !pm;
        end else begin
            next_flags.precision = u_inx;
            next_trap            = u_inx && !pm;
        end
    end

    // ====================================================================
    // Result pipeline stage
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_valid  <= 1'b0;
            res_result <= 64'h0;
            res_flags  <= '0;
            trap       <= 1'b0;
        end else begin
            res_valid  <= req_valid;
            res_result <= req_valid ? next_result : res_result;
            res_flags  <= req_valid ? next_flags : '0;
            trap       <= req_valid && next_trap;
        end
    end

    assign exc_vector = SFX_EXC_VECTOR;

    // ====================================================================
    // Register writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl <= SFX_CTRL_RESET;
        end else if (reg_wr && reg_addr == SFX_ADDR_CTRL) begin
            ctrl <= reg_wdata[4:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_mask <= SFX_IRQ_MASK_RESET;
        end else if (reg_wr && reg_addr == SFX_ADDR_IRQ_MASK) begin
            irq_mask <= reg_wdata[2:0];
        end
    end

    // Sticky flags: a new result's flag wins over a write-one clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags <= SFX_FLAGS_RESET;
        end else begin
            flags <= (flags & ~((reg_wr && reg_addr == SFX_ADDR_FLAGS) ?
                                reg_wdata[2:0] : 3'h0)) | res_flags;
        end
    end

    assign irq = |(flags & irq_mask);

    // ====================================================================
    // Register reads
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SFX_ADDR_CTRL:     reg_rdata <= {27'h0, ctrl};
                SFX_ADDR_FLAGS:    reg_rdata <= {29'h0, flags};
                SFX_ADDR_IRQ_MASK: reg_rdata <= {29'h0, irq_mask};
                default:           reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ====================================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_tiny_masked;
        req_valid && tiny && um;
    endsequence

    sequence s_tiny_unmasked;
        req_valid && tiny && !um;
    endsequence

    sequence s_plain_inexact;
        req_valid && nz && u_inx && !tiny && !huge;
    endsequence

    a_sp_tiny_detect: assert property (
        req_valid && !req.dbl && nz && int'(exp_r) < SFX_SP_EMIN && !um
        |=> trap && res_flags.underflow)
        else $error("single tiny result did not raise underflow");

    a_dp_tiny_detect: assert property (
        req_valid && req.dbl && nz && int'(exp_r) < SFX_DP_EMIN && !um
        |=> trap && res_flags.underflow)
        else $error("double tiny result did not raise underflow");

    a_unf_masked_pair: assert property (
        s_tiny_masked |=> res_flags.underflow == res_flags.precision
                          && res_flags.underflow == $past(d_inx))
        else $error("masked underflow flags not paired with inexact");

    a_unf_unmasked_flags: assert property (
        s_tiny_unmasked |=> trap && res_flags.underflow
                            && res_flags.precision == $past(u_inx))
        else $error("unmasked underflow flags wrong");

    a_unf_sp_scaled: assert property (
        s_tiny_unmasked and !req.dbl
        |=> res_result[30:23] == 8'($past(exp_r) + 16'(SFX_SP_SCALE + SFX_SP_BIAS)))
        else $error("single underflow result not scaled by 2^192");

    a_ovf_sp_scaled: assert property (
        req_valid && huge && !om && !req.dbl
        |=> trap && res_result[30:23]
            == 8'($past(exp_r) - 16'(SFX_SP_SCALE - SFX_SP_BIAS)))
        else $error("single overflow result not scaled by 2^-192");

    a_inexact_masked: assert property (
        s_plain_inexact and pm |=> res_flags.precision && !trap)
        else $error("masked inexact mishandled");

    a_inexact_trap: assert property (
        s_plain_inexact and !pm
        |=> trap && res_flags.precision ##1 (!trap || $past(req_valid)))
        else $error("unmasked inexact did not trap for one cycle");

    a_trap_vector: assert property (
        trap |-> res_valid && exc_vector == 8'h13)
        else $error("trap without vector 19");

    a_flag_sticky: assert property (
        res_valid && res_flags.precision |=> flags.precision)
        else $error("precision flag not captured");

endmodule // sfx_exc_unit

// file: common/sfx_pkg.sv
// Constants and carrier types for the SIMD floating-point underflow and inexact unit.
package sfx_pkg;

    // ====================================================================
    // Register map
    localparam logic [3:0] SFX_ADDR_CTRL      = 4'h0;
    localparam logic [3:0] SFX_ADDR_FLAGS     = 4'h4;
    localparam logic [3:0] SFX_ADDR_IRQ_MASK  = 4'h8;
    localparam int         SFX_CTRL_OM_BIT    = 0;
    localparam int         SFX_CTRL_UM_BIT    = 1;
    localparam int         SFX_CTRL_PM_BIT    = 2;
    localparam int         SFX_CTRL_RM_LSB    = 3;
    localparam logic [4:0] SFX_CTRL_RESET     = 5'h07;
    localparam logic [2:0] SFX_FLAGS_RESET    = 3'h0;
    localparam logic [2:0] SFX_IRQ_MASK_RESET = 3'h0;

    // ====================================================================
    // Format constants
    localparam int         SFX_SP_PREC  = 24;
    localparam int         SFX_DP_PREC  = 53;
    localparam int         SFX_SP_EMIN  = -126;
    localparam int         SFX_DP_EMIN  = -1022;
    localparam int         SFX_SP_EMAX  = 127;
    localparam int         SFX_DP_EMAX  = 1023;
    localparam int         SFX_SP_BIAS  = 127;
    localparam int         SFX_DP_BIAS  = 1023;
    localparam int         SFX_SP_SCALE = 192;
    localparam int         SFX_DP_SCALE = 1536;
    localparam logic [7:0] SFX_EXC_VECTOR = 8'h13;

    // ====================================================================
    // Types
    typedef enum logic [1:0] {
        SFX_RM_NEAREST = 2'h0,
        SFX_RM_DOWN    = 2'h1,
        SFX_RM_UP      = 2'h2,
        SFX_RM_ZERO    = 2'h3
    } sfx_rmode_t;

    typedef struct packed {
        logic        precision;
        logic        underflow;
        logic        overflow;
    } sfx_flags_t;

    // Unrounded result: value = sig / 2^63 * 2^exp, sig normalised or zero.
    typedef struct packed {
        logic        dbl;
        logic        sign;
        logic [15:0] exp;
        logic [63:0] sig;
    } sfx_req_t;

endpackage

// file: verilog/sfx_round.sv
// Rounds a significand to a given number of leading bits in the selected mode.
`timescale 1ns/1ps

module sfx_round
    import sfx_pkg::*;
(
    input  wire logic [63:0] sig,
    input  wire logic [6:0]  keep,
    input  wire logic        sign,
    input  wire sfx_rmode_t  rmode,
    output logic      [64:0] q,
    output logic             inexact
);
    logic [6:0]  shift;
    logic [63:0] rem;
    logic        guard;
    logic        sticky;
    logic        inc;

    always_comb begin
        shift   = 7'd64 - keep;
        rem     = sig & ~({64{1'b1}} << shift);
        guard   = (keep < 7'd64) ? sig[6'(7'd63 - keep)] : 1'b0;
        sticky  = |(rem & ~(64'h1 << (7'd63 - keep)));
        inexact = guard | sticky;
        unique case (rmode)
            SFX_RM_NEAREST: inc = guard & (sticky | (((sig >> shift) & 64'h1) != 64'h0));
            SFX_RM_DOWN:    inc = sign & inexact;
            SFX_RM_UP:      inc = ~sign & inexact;
            SFX_RM_ZERO:    inc = 1'b0;
        endcase
        q = {1'b0, sig >> shift} + {64'h0, inc};
    end

endmodule // sfx_round

// file: tb/sfx_tb.sv
// Self-checking testbench for the SIMD floating-point underflow and inexact unit.
`timescale 1ns/1ps

module tb;
    import sfx_pkg::*;

    // ====================================================================
    // Stimulus signals and design instance
    logic        ref_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        req_valid = 1'b0;
    sfx_req_t    req       = '0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        res_valid;
    logic [63:0] res_result;
    sfx_flags_t  res_flags;
    logic        trap;
    logic [7:0]  exc_vector;
    logic [31:0] reg_rdata;
    logic        irq;
    logic        rd_d      = 1'b0;
    logic [75:0] exp_q[$];
    logic [31:0] rd_q[$];
    int          fails     = 0;
    int          n_checks  = 0;
    localparam logic [63:0] ONE   = 64'h8000_0000_0000_0000;
    localparam logic [63:0] ONE_P = 64'h8000_0000_0000_0001;
    localparam logic [63:0] RND_UP = 64'h8000_0080_0000_0001;

    always #5 ref_clk = ~ref_clk;

    sfx_exc_unit sfx_exc_unit_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req(req), .res_valid(res_valid), .res_result(res_result), .res_flags(res_flags),
        .trap(trap), .exc_vector(exc_vector), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    // ====================================================================
    // Drivers: each note of the expected result is queued as it is sent
    task automatic op(input logic d, input logic s, input int e, input logic [63:0] g,
                      input logic [63:0] r, input logic [2:0] f, input logic t);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        req       <= '{dbl: d, sign: s, exp: 16'(e), sig: g};
        exp_q.push_back({r, f, t, 8'h13});
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        reg_addr  <= a;
        rd_q.push_back(v);
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            req_valid <= 1'b0;
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
        end
    endtask

    task automatic cmp_res(input logic [75:0] got, input logic [75:0] want, input string what);
        n_checks++;
        if (got !== want) begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] want, input string what);
        n_checks++;
        if (got !== want) begin
            fails++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic cmp_irq(input logic got, input logic want, input string what);
        n_checks++;
        if (got !== want) begin
            fails++;
            $display("BAD %0t %s got %b want %b", $time, what, got, want);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ====================================================================
    // Monitor: the oldest note is taken off whenever a result shows
    always @(posedge ref_clk) begin
        rd_d <= reg_rd;
        if (res_valid === 1'b1) begin
            if (exp_q.size() == 0) cmp_res(76'h1, 76'h0, "stray result");
            else cmp_res({res_result, res_flags, trap, exc_vector}, exp_q.pop_front(),
                         "op");
        end
        if (rd_d) begin
            if (rd_q.size() == 0) cmp_reg(32'h1, 32'h0, "stray read");
            else cmp_reg(reg_rdata, rd_q.pop_front(), "reg");
        end
    end

    // ====================================================================
    // Main sequence
    logic [63:0] pos_ovf[4] = '{64'h7f800000, 64'h7f7fffff, 64'h7f800000, 64'h7f7fffff};
    logic [63:0] neg_ovf[4] = '{64'hff800000, 64'hff800000, 64'hff7fffff, 64'hff7fffff};
    logic [63:0] pos_rnd[4] = '{64'h3f800001, 64'h3f800000, 64'h3f800001, 64'h3f800000};
    logic [63:0] neg_rnd[4] = '{64'hbf800001, 64'hbf800001, 64'hbf800000, 64'hbf800000};

    initial begin
        int          e;
        logic        s;
        logic [22:0] fr;
        void'($urandom(45));
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(SFX_ADDR_CTRL, 32'h07);
        rd(SFX_ADDR_FLAGS, 32'h0);
        rd(SFX_ADDR_IRQ_MASK, 32'h0);
        wr(4'hc, 32'hffffffff);
        rd(4'hc, 32'h0);
        // All exceptions masked: bounded results, no traps.
        op(0, 0, 0, ONE, 64'h3f800000, 3'h0, 0);
        op(0, 0, 0, ONE_P, 64'h3f800000, 3'h4, 0);
        op(0, 0, -127, ONE, 64'h00400000, 3'h0, 0);
        op(0, 0, -127, ONE_P, 64'h00400000, 3'h6, 0);
        op(1, 0, -1022, ONE, 64'h0010000000000000, 3'h0, 0);
        op(1, 0, -1023, ONE_P, 64'h0008000000000000, 3'h6, 0);
        op(0, 1, 0, 64'h0, 64'h80000000, 3'h0, 0);
        op(0, 0, 128, ONE, 64'h7f800000, 3'h5, 0);
        for (int i = 0; i < 16; i++) begin
            e  = int'($urandom_range(200)) - 100;
            s  = 1'($urandom());
            fr = 23'($urandom());
            op(0, s, e, {1'b1, fr, 40'h0}, {32'h0, s, 8'(e + 127), fr}, 3'h0, 0);
        end
        idle(3);
        rd(SFX_ADDR_FLAGS, 32'h7);
        wr(SFX_ADDR_FLAGS, 32'h7);
        rd(SFX_ADDR_FLAGS, 32'h0);
        // Underflow unmasked: scaled result to the handler.
        wr(SFX_ADDR_CTRL, 32'h05);
        idle(1);
        op(0, 0, -127, ONE, 64'h60000000, 3'h2, 1);
        op(0, 0, -127, ONE_P, 64'h60000000, 3'h6, 1);
        op(1, 0, -1023, ONE, 64'h6000000000000000, 3'h2, 1);
        op(0, 0, 0, ONE_P, 64'h3f800000, 3'h4, 0);
        // Precision unmasked.
        wr(SFX_ADDR_CTRL, 32'h03);
        idle(1);
        op(0, 0, 0, ONE_P, 64'h3f800000, 3'h4, 1);
        op(0, 0, -127, ONE_P, 64'h00400000, 3'h6, 1);
        op(0, 0, 128, ONE, 64'h7f800000, 3'h5, 1);
        op(0, 0, 0, ONE, 64'h3f800000, 3'h0, 0);
        // Overflow unmasked.
        wr(SFX_ADDR_CTRL, 32'h06);
        idle(1);
        op(0, 0, 128, ONE, 64'h1f800000, 3'h1, 1);
        op(1, 0, 1024, ONE, 64'h1ff0000000000000, 3'h1, 1);
        // Masked overflow in every rounding mode, both signs.
        for (int m = 0; m < 4; m++) begin
            wr(SFX_ADDR_CTRL, {27'h0, 2'(m), 3'h7});
            idle(1);
            op(0, 0, 128, ONE, pos_ovf[m], 3'h5, 0);
            op(0, 1, 128, ONE, neg_ovf[m], 3'h5, 0);
            op(0, 0, 0, RND_UP, pos_rnd[m], 3'h4, 0);
            op(0, 1, 0, RND_UP, neg_rnd[m], 3'h4, 0);
        end
        // Interrupt: raised, masked and cleared.
        idle(3);
        wr(SFX_ADDR_IRQ_MASK, 32'h1);
        idle(2);
        cmp_irq(irq, 1'b1, "irq set");
        wr(SFX_ADDR_IRQ_MASK, 32'h0);
        idle(2);
        cmp_irq(irq, 1'b0, "irq masked");
        wr(SFX_ADDR_IRQ_MASK, 32'h1);
        wr(SFX_ADDR_FLAGS, 32'h1);
        idle(2);
        cmp_irq(irq, 1'b0, "irq cleared");
        rd(SFX_ADDR_FLAGS, 32'h6);
        idle(1);
        // Drain with a bounded wait; a leftover note counts as a mismatch.
        for (int i = 0; i < 50 && (exp_q.size() + rd_q.size()) > 0; i++) @(posedge ref_clk);
        if ((exp_q.size() + rd_q.size()) > 0) cmp_res(76'h1, 76'h0, "timeout");
        close_out();
    end

endmodule // tb
